// >>> common/cmb_pkg.sv
// Package of message buffer layout and register constants for the CAN buffer link.
`default_nettype none
package cmb_pkg;
  // Buffer word layout.
  localparam int WORDS         = 8;
  localparam int BID_MSB       = 12;
  localparam int BID_LSB       = 2;
  localparam int SRR_BIT       = 1;
  localparam int IDE_BIT       = 0;
  localparam int EXTH_MSB      = 11;
  localparam int EXTL_MSB      = 15;
  localparam int EXTL_LSB      = 10;
  localparam int RTR_BIT       = 9;
  localparam int RB1_BIT       = 8;
  localparam int RB0_BIT       = 4;
  localparam int DLC_MSB       = 3;
  localparam int FIDX_MSB      = 12;
  localparam int FIDX_LSB      = 8;
  localparam logic [15:0] W0_MASK = 16'h1fff;
  localparam logic [15:0] W1_MASK = 16'h0fff;
  localparam logic [15:0] W2_MASK = 16'hff1f;
  localparam logic [15:0] W7_MASK = 16'h1f00;
  localparam logic [15:0] TXD_RESET = 16'h0000;
  // Controller APB registers (byte addresses).
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TXD    = 8'h08;
  localparam logic [7:0] REG_FRAME0 = 8'h0c;
  localparam logic [7:0] REG_FRAME1 = 8'h10;
  localparam logic [7:0] REG_DATA0  = 8'h14;
  localparam logic [7:0] REG_DATA1  = 8'h18;
  // Control register fields.
  localparam int CTRL_DIR   = 0;
  localparam int CTRL_SEND  = 1;
  localparam int CTRL_FIDX_LSB = 8;
endpackage : cmb_pkg
`default_nettype wire

// >>> common/cmb_link_if.sv
// Word link between the buffer-moving end and the CAN controller end.
`timescale 1ns/1ps
`default_nettype none
interface cmb_link_if;
  logic        tx_valid;
  logic [15:0] tx_word;
  logic        tx_ready;
  logic        rx_valid;
  logic [15:0] rx_word;
  logic        rx_ready;
  modport mover (output tx_valid, output tx_word, input tx_ready,
                 input rx_valid, input rx_word, output rx_ready);
  modport ctrl  (input tx_valid, input tx_word, output tx_ready,
                 output rx_valid, output rx_word, input rx_ready);
endinterface : cmb_link_if
`default_nettype wire

// >>> hdl/cmb_mover.sv
// Buffer-moving end: holds one eight-word buffer in RAM and streams it over the link.
`timescale 1ns/1ps
`default_nettype none
module cmb_mover (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Link to the controller.
  cmb_link_if.mover        link,
  // Software buffer port.
  input  wire logic        ram_we,
  input  wire logic [2:0]  ram_addr,
  input  wire logic [15:0] ram_wdata,
  output logic      [15:0] ram_rdata,
  input  wire logic        start_tx
);
  typedef struct packed {
    logic [cmb_pkg::WORDS-1:0][15:0] ram;
    logic [15:0] rdata;
    logic        busy;
    logic [2:0]  tidx;
    logic [2:0]  ridx;
    logic        vld;
    logic [15:0] word;
    logic        rrdy;
  } cmb_mv_t;
  cmb_mv_t s, next_s;

  always_comb begin
    next_s = s;
    next_s.rrdy = 1'b1;
    // Software writes the buffer directly in RAM.
    if (ram_we) begin
      next_s.ram[ram_addr] = ram_wdata;
    end
    if (!s.busy && start_tx) begin
      next_s.busy = 1'b1;
      next_s.tidx = 3'h0;
      next_s.vld  = 1'b1;
      next_s.word = s.ram[0];
    end else if (s.vld && link.tx_ready) begin
      if (s.tidx == 3'h7) begin
        next_s.vld  = 1'b0;
        next_s.busy = 1'b0;
      end else begin
        next_s.tidx = s.tidx + 3'h1;
        next_s.word = s.ram[s.tidx + 3'h1];
      end
    end
    // Received words land in order, word 7 carries the filter index.
    if (link.rx_valid && s.rrdy) begin
      next_s.ram[s.ridx] = link.rx_word;
      next_s.ridx = s.ridx + 3'h1;
    end
    next_s.rdata = s.ram[ram_addr];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.tx_valid = s.vld;
  assign link.tx_word  = s.word;
  assign link.rx_ready = s.rrdy;
  assign ram_rdata     = s.rdata;
endmodule : cmb_mover
`default_nettype wire

// >>> hdl/cmb_ctrl.sv
// Controller end: transmit data word, frame assembly and receive buffer emission over APB.
// Function
// - Software places buffers in ordinary RAM.
// - Word 0 bits 12-2 hold base identifier.
// - Word 0 bit 1 is remote for standard.
// - Extended messages need SRR set to one.
// - Word 0 bit 0 selects extended identifier.
// - Word 1 bits 11-0 hold extension high.
// - Word 2 bits 15-10 hold extension low.
// - Word 2 bit 9 is remote for extended.
// - Standard frames ignore RTR, use SRR.
// - Software writes reserved bit 8 zero.
// - Software writes reserved bit 4 zero.
// - Word 2 bits 3-0 hold data length.
// - Word 2 bits 7-5 read zero.
// - Words 3-6 hold data byte pairs.
// - Word 7 bits 12-8 hold filter index.
// - Filter index written only for receive buffers.
// - Sixteen bit transmit data register, reset zero.
// - Direction bit: one transmit, zero receive.
// - Send request clears after successful send.
`timescale 1ns/1ps
`default_nettype none
module cmb_ctrl (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Link to the buffer mover.
  cmb_link_if.ctrl         link,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  // One record holds every register of the controller; next_s is its next value.
  typedef struct packed {
    logic        dir;
    logic        send;
    logic [4:0]  fidx;
    logic [15:0] txd;
    logic [2:0]  widx;
    logic [10:0] bid;
    logic [17:0] ext;
    logic        ide;
    logic        remote;
    logic [3:0]  dlc;
    logic [7:0][7:0] data;
    logic        done;
    logic        rx_go;
    logic        rx_vld;
    logic [2:0]  ridx;
    logic [15:0] rword;
    logic [31:0] rdata;
    logic        rdy;
    logic        err;
    logic        txr;
  } cmb_ct_t;
  cmb_ct_t s, next_s;

  logic        acc;
  logic        fin;
  logic        wr_hit;
  logic        tx_take;
  logic        tx_last;
  logic [15:0] w;
  logic [15:0] rx_img;

  // The slave answers with one wait state: acc marks the first access cycle, fin the cycle
  // in which pready is high and the master completes the transfer.
  assign acc     = psel && penable && !s.rdy;
  assign fin     = psel && penable && s.rdy;
  // Only the control, status and transmit data words accept writes.
  assign wr_hit  = (paddr == cmb_pkg::REG_CTRL) || (paddr == cmb_pkg::REG_STATUS) ||
                   (paddr == cmb_pkg::REG_TXD);
  // A word moves when the mover offers it and transmission is enabled.
  assign tx_take = link.tx_valid && s.txr;
  assign tx_last = tx_take && (s.widx == 3'h7);

  always_comb begin
    next_s = s;
    // pready is a one-cycle pulse that follows the first access cycle.
    next_s.rdy = acc;
    next_s.err = 1'b0;
    w = 16'h0000;
    rx_img = 16'h0000;
    // Transmit: accept words 0..7 into the data register, one per handshake.
    // Fields come from fixed word positions, so the mover must never skip a word.
    if (tx_take) begin
      w = link.tx_word;
      next_s.txd  = w;
      next_s.widx = s.widx + 3'h1;
      unique case (s.widx)
        3'h0: begin
          next_s.bid = w[cmb_pkg::BID_MSB:cmb_pkg::BID_LSB];
          next_s.ide = w[cmb_pkg::IDE_BIT];
          next_s.remote = w[cmb_pkg::SRR_BIT];
        end
        3'h1: next_s.ext[17:6] = w[cmb_pkg::EXTH_MSB:0];
        3'h2: begin
          next_s.ext[5:0] = w[cmb_pkg::EXTL_MSB:cmb_pkg::EXTL_LSB];
          next_s.dlc = w[cmb_pkg::DLC_MSB:0];
          // Standard frames keep the remote flag taken from SRR in word 0.
          if (s.ide) next_s.remote = w[cmb_pkg::RTR_BIT];
        end
        3'h3, 3'h4, 3'h5, 3'h6: begin
          // Word 3+k carries byte 2k in its low half and byte 2k+1 in its high half.
          next_s.data[{s.widx - 3'h3, 1'b0}] = w[7:0];
          next_s.data[{s.widx - 3'h3, 1'b1}] = w[15:8];
        end
        3'h7: begin
          // Filter index of a transmit buffer is never interpreted.
          next_s.send = 1'b0;
          next_s.done = 1'b1;
        end
      endcase
    end
    // Receive: emit the stored frame as a buffer image, words 0..7.
    // The image is rebuilt from the frame held here, so a receive run replays the last
    // frame that was assembled; nothing is fetched back from the mover.
    unique case (s.ridx)
      // An extended frame always carries SRR as one; only a standard frame shows remote there.
      3'h0: rx_img = {3'h0, s.bid, s.remote | s.ide, s.ide} & cmb_pkg::W0_MASK;
      3'h1: rx_img = {4'h0, s.ext[17:6]} & cmb_pkg::W1_MASK;
      // Both reserved bits and the unused bits 7 to 5 are driven as zero.
      3'h2: rx_img = {s.ext[5:0], s.remote & s.ide, 1'b0, 3'h0, 1'b0, s.dlc} & cmb_pkg::W2_MASK;
      3'h3, 3'h4, 3'h5, 3'h6: rx_img = {s.data[{s.ridx - 3'h3, 1'b1}], s.data[{s.ridx - 3'h3, 1'b0}]};
      3'h7: rx_img = {3'h0, s.fidx, 8'h00} & cmb_pkg::W7_MASK;
    endcase
    // Each word stands one cycle and is followed by a gap, which keeps the mover's store simple.
    if (!s.rx_vld && s.rx_go) begin
      next_s.rx_vld = 1'b1;
      next_s.rword  = rx_img;
    end else if (s.rx_vld && link.rx_ready) begin
      next_s.ridx = s.ridx + 3'h1;
      next_s.rx_vld = 1'b0;
      if (s.ridx == 3'h7) next_s.rx_go = 1'b0;
    end
    // Writes take effect only at the edge at which the master samples pready high; a refused
    // write is flagged on the first access cycle so that pslverr stands beside pready.
    if (acc && pwrite && !wr_hit) begin
      next_s.err = 1'b1;
    end
    if (fin && pwrite && wr_hit) begin
      unique case (paddr)
        cmb_pkg::REG_CTRL: begin
          // Send with dir set starts a transmit run; send with dir clear replays the frame
          // as a receive buffer image instead, so it never requests a transmission.
          next_s.dir  = pwdata[cmb_pkg::CTRL_DIR];
          next_s.fidx = pwdata[cmb_pkg::CTRL_FIDX_LSB +: 5];
          if (pwdata[cmb_pkg::CTRL_SEND] && pwdata[cmb_pkg::CTRL_DIR]) begin
            next_s.send = 1'b1;
            next_s.widx = 3'h0;
          end
          if (!pwdata[cmb_pkg::CTRL_DIR] && pwdata[cmb_pkg::CTRL_SEND]) begin
            next_s.rx_go = 1'b1;
            next_s.ridx = 3'h0;
          end
        end
        cmb_pkg::REG_STATUS: begin
          // The set of done by the last word wins over a clear in the same cycle.
          if (!tx_last) begin
            next_s.done = 1'b0;
          end
        end
        cmb_pkg::REG_TXD: next_s.txd = pwdata[15:0];
        default: begin
        end
      endcase
    end
    // Reads are decoded on the first access cycle; prdata is registered and stands with pready.
    if (acc && !pwrite) begin
      unique case (paddr)
        cmb_pkg::REG_CTRL:   next_s.rdata = {19'h0, s.fidx, 6'h0, s.send, s.dir};
        cmb_pkg::REG_STATUS: next_s.rdata = {25'h0, s.rx_go, s.widx, s.done, s.remote, s.ide};
        cmb_pkg::REG_TXD:    next_s.rdata = {16'h0, s.txd};
        cmb_pkg::REG_FRAME0: next_s.rdata = {21'h0, s.bid};
        cmb_pkg::REG_FRAME1: next_s.rdata = {10'h0, s.dlc, s.ext};
        cmb_pkg::REG_DATA0:  next_s.rdata = s.data[3:0];
        cmb_pkg::REG_DATA1:  next_s.rdata = s.data[7:4];
        default: begin
          next_s.rdata = 32'h0;
          next_s.err = 1'b1;
        end
      endcase
    end
    // tx_ready is registered as well, so the mover sees it straight from a flip-flop.
    next_s.txr = next_s.dir && next_s.send;
  end

  // The asynchronous reset clears every field, so the transmit data word starts at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Every output comes straight from a field of the state record.
  assign link.tx_ready = s.txr;
  assign link.rx_valid = s.rx_vld;
  assign link.rx_word  = s.rword;
  assign prdata  = s.rdata;
  assign pready  = s.rdy;
  assign pslverr = s.err;
endmodule : cmb_ctrl
`default_nettype wire

// >>> sim/cmb_link_sva.sv
// Checker of the word link between the two buffer ends.
`timescale 1ns/1ps
`default_nettype none
module cmb_link_sva (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // Link signals.
  input wire logic        tx_valid,
  input wire logic [15:0] tx_word,
  input wire logic        tx_ready,
  input wire logic        rx_valid,
  input wire logic [15:0] rx_word,
  input wire logic        rx_ready
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] tc;
  logic [2:0] rc;
  logic       tk;
  assign tk = tx_valid && tx_ready;
  // Word counters locate the field layout of each word on the wire.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc <= 3'h0;
      rc <= 3'h0;
    end else begin
      tc <= tc + 3'(tk);
      rc <= rc + 3'(rx_valid && rx_ready);
    end
  end
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_word); endproperty
  a_hold: assert property (p_hold) else $error("tx word dropped");
  property p_gap; rx_valid |=> !rx_valid; endproperty
  a_gap: assert property (p_gap) else $error("rx no gap");
  property p_w0; rx_valid && rc == 3'h0 |-> (rx_word & ~cmb_pkg::W0_MASK) == 16'h0000; endproperty
  a_w0: assert property (p_w0) else $error("word 0 spare bits");
  property p_w1; rx_valid && rc == 3'h1 |-> (rx_word & ~cmb_pkg::W1_MASK) == 16'h0000; endproperty
  a_w1: assert property (p_w1) else $error("word 1 spare bits");
  property p_w2; rx_valid && rc == 3'h2 |-> (rx_word & ~cmb_pkg::W2_MASK) == 16'h0000; endproperty
  a_w2: assert property (p_w2) else $error("word 2 spare bits");
  property p_w7; rx_valid && rc == 3'h7 |-> (rx_word & ~cmb_pkg::W7_MASK) == 16'h0000; endproperty
  a_w7: assert property (p_w7) else $error("word 7 spare bits");
  property p_clr; tk && tc == 3'h7 |=> !tx_ready; endproperty
  a_clr: assert property (p_clr) else $error("send not cleared");
  property p_stop; tk && tc == 3'h7 |=> !tx_valid; endproperty
  a_stop: assert property (p_stop) else $error("words past seven");
  c_tx: cover property (tk && tc == 3'h7);
  c_rx: cover property (rx_valid && rc == 3'h7 && rx_ready);
  c_stall: cover property (tx_valid && !tx_ready);
endmodule : cmb_link_sva
`default_nettype wire

// >>> sim/can_message_buffer_format_bench.sv
// Testbench joining both buffer ends over the word link.
`timescale 1ns/1ps
`default_nettype none
module can_message_buffer_format_bench;
  logic        pclk;
  logic        presetn;
  logic        ram_we;
  logic [2:0]  ram_addr;
  logic [15:0] ram_wdata;
  logic [15:0] ram_rdata;
  logic        start_tx;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  logic        er;
  logic [15:0] wv [8];
  int          failures;
  int          cmp_count;
  cmb_link_if link ();
  cmb_mover i_cmb_mover (.pclk(pclk), .presetn(presetn), .link(link), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .start_tx(start_tx));
  cmb_ctrl i_cmb_ctrl (.pclk(pclk), .presetn(presetn), .link(link), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  cmb_link_sva i_cmb_link_sva (.pclk(pclk), .presetn(presetn), .tx_valid(link.tx_valid),
    .tx_word(link.tx_word), .tx_ready(link.tx_ready), .rx_valid(link.rx_valid),
    .rx_word(link.rx_word), .rx_ready(link.rx_ready));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No limit of its own: only the watchdog ends a hung transfer.
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic t_reg();
    apb(1'b0, cmb_pkg::REG_TXD, 32'h0);
    chk("txd reset", rd, 32'h0);
    apb(1'b1, cmb_pkg::REG_TXD, 32'h1234abcd);
    apb(1'b0, cmb_pkg::REG_TXD, 32'h0);
    chk("txd rw", rd, 32'h0000abcd);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped", {rd[30:0], er}, 32'h1);
  endtask : t_reg
  task automatic t_frame(input logic [15:0] w0, w1, w2, input logic ide, rem);
    wv[0] = w0;
    wv[1] = w1;
    wv[2] = w2;
    wv[7] = 16'h5a5a;
    for (int k = 3; k < 7; k++)
      wv[k] = {8'(8'ha1 + 2 * k), 8'(8'ha0 + 2 * k)};
    for (int k = 0; k < 8; k++) begin
      @(posedge pclk);
      ram_we    <= 1'b1;
      ram_addr  <= 3'(k);
      ram_wdata <= wv[k];
    end
    @(posedge pclk);
    ram_we   <= 1'b0;
    start_tx <= 1'b1;
    @(posedge pclk);
    start_tx <= 1'b0;
    // Send is raised late so that the mover has to hold its first word.
    apb(1'b1, cmb_pkg::REG_CTRL, 32'h3);
    repeat (30) begin
      apb(1'b0, cmb_pkg::REG_STATUS, 32'h0);
      if (rd[2] === 1'b1) break;
    end
    chk("done", 32'(rd[2]), 32'h1);
    chk("ide", 32'(rd[0]), 32'(ide));
    chk("remote", 32'(rd[1]), 32'(rem));
    apb(1'b0, cmb_pkg::REG_FRAME0, 32'h0);
    chk("base id", rd, 32'(w0[12:2]));
    apb(1'b0, cmb_pkg::REG_FRAME1, 32'h0);
    chk("dlc ext", rd, {10'h0, w2[3:0], w1[11:0], w2[15:10]});
    apb(1'b0, cmb_pkg::REG_DATA0, 32'h0);
    chk("data0", rd, 32'ha9a8a7a6);
    apb(1'b0, cmb_pkg::REG_DATA1, 32'h0);
    chk("data1", rd, 32'hadacabaa);
    apb(1'b0, cmb_pkg::REG_TXD, 32'h0);
    chk("last txd", rd, 32'h5a5a);
    apb(1'b0, cmb_pkg::REG_CTRL, 32'h0);
    chk("send", 32'(rd[1]), 32'h0);
    chk("fidx kept", 32'(rd[12:8]), 32'h0);
    apb(1'b1, cmb_pkg::REG_STATUS, 32'h0);
  endtask : t_frame
  task automatic t_rx();
    apb(1'b1, cmb_pkg::REG_CTRL, 32'h1302);
    repeat (30) begin
      apb(1'b0, cmb_pkg::REG_STATUS, 32'h0);
      if (rd[6] === 1'b0) break;
    end
    chk("rx done", 32'(rd[6]), 32'h0);
    for (int k = 0; k < 8; k++) begin
      @(posedge pclk);
      ram_addr <= 3'(k);
      repeat (2) @(posedge pclk);
      chk("rx word", 32'(ram_rdata), k == 7 ? 32'h1300 : 32'(wv[k]));
    end
  endtask : t_rx
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    #400000;
    failures++;
    end_of_test();
  end
  initial begin
    presetn  = 1'b0;
    ram_we   = 1'b0;
    ram_addr = 3'h0;
    ram_wdata = 16'h0;
    start_tx = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h0;
    pwdata   = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reg();
    t_frame(16'h168f, 16'h0bcd, 16'hb608, 1'b1, 1'b1);
    t_frame(16'h1ffc, 16'h0000, 16'h020f, 1'b0, 1'b0);
    t_frame(16'h0006, 16'h0000, 16'h0000, 1'b0, 1'b1);
    t_rx();
    end_of_test();
  end
endmodule : can_message_buffer_format_bench
`default_nettype wire
